// ### hw/oag_pkg.sv
package oag_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int ADDR_W      = 16;
  localparam int DATA_W      = 8;
  localparam int MODE_W      = 5;
  localparam logic [15:0] ZERO_ADDR   = 16'h0000;
  localparam logic [15:0] PAGE0_LAST  = 16'h00ff;
  localparam logic [15:0] SHORT_IDX_MAX = 16'h01fe;
  localparam logic [15:0] ADDR_STEP   = 16'h0001;
  localparam logic [7:0]  ZERO_BYTE   = 8'h00;
  localparam logic [2:0]  LEN_ONE     = 3'h1;
  localparam logic [2:0]  LEN_TWO     = 3'h2;
  localparam logic [2:0]  LEN_STEP    = 3'h1;
  localparam logic [2:0]  LEN_ZERO    = 3'h0;

  // ****************************************
  // Addressing modes
  // ****************************************
  typedef enum logic [4:0] {
    OAG_M_INHERENT    = 5'h00,
    OAG_M_IMMEDIATE   = 5'h01,
    OAG_M_DIR_SHORT   = 5'h02,
    OAG_M_DIR_LONG    = 5'h03,
    OAG_M_IDX_NONE    = 5'h04,
    OAG_M_IDX_SHORT   = 5'h05,
    OAG_M_IDX_LONG    = 5'h06,
    OAG_M_IND_SHORT   = 5'h07,
    OAG_M_IND_LONG    = 5'h08,
    OAG_M_INDIDX_SHORT = 5'h09,
    OAG_M_INDIDX_LONG = 5'h0a,
    OAG_M_REL_DIR     = 5'h0b,
    OAG_M_REL_IND     = 5'h0c
  } oag_mode_e;

  // ****************************************
  // Sequencer states
  // ****************************************
  typedef enum logic [2:0] {
    OAG_S_IDLE  = 3'h0,
    OAG_S_OPND1 = 3'h1,
    OAG_S_OPND2 = 3'h2,
    OAG_S_PTR1  = 3'h3,
    OAG_S_PTR2  = 3'h4,
    OAG_S_DONE  = 3'h5
  } oag_state_e;

endpackage

// ### hw/oag_mem_if.sv
`timescale 1ns/1ps
// Byte read channel between the sequencer and its memory port stage
interface oag_mem_if;
  logic        req;
  logic [15:0] addr;
  logic        ack;
  logic [7:0]  data;
  modport master (output req, output addr, input ack, input data);
  modport port   (input req, input addr, output ack, output data);
endinterface

// ### hw/oag_mem_port.sv
`timescale 1ns/1ps
// Registers one byte read onto the core memory bus
module oag_mem_port
  import oag_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  oag_mem_if.port          rd,
  output      logic        mem_rd_o,
  output      logic [15:0] mem_addr_o,
  input  wire logic [7:0]  mem_rdata_i
);

  typedef struct packed {
    logic        busy;
    logic        rd;
    logic [15:0] addr;
    logic        ack;
    logic [7:0]  data;
  } oag_port_s;

  oag_port_s port_reg;
  oag_port_s port_next;

  // Memory answers within the strobe cycle; data captured into a register at its end
  always_comb begin
    port_next     = port_reg;
    port_next.ack = 1'b0;
    port_next.rd  = 1'b0;
    if (port_reg.busy) begin
      port_next.busy = 1'b0;
      port_next.ack  = 1'b1;
      port_next.data = mem_rdata_i;
    end else if (rd.req && !port_reg.ack) begin
      port_next.busy = 1'b1;
      port_next.rd   = 1'b1;
      port_next.addr = rd.addr;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      port_reg <= '0;
    end else begin
      port_reg <= port_next;
    end
  end

  assign rd.ack     = port_reg.ack;
  assign rd.data    = port_reg.data;
  assign mem_rd_o   = port_reg.rd;
  assign mem_addr_o = port_reg.addr;

endmodule

// ### hw/oag_top.sv
`timescale 1ns/1ps
module oag_top
  import oag_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  input  wire logic        start_i,
  input  wire logic [4:0]  mode_i,
  input  wire logic        use_y_i,
  input  wire logic        rmw_i,
  input  wire logic [15:0] pc_i,
  input  wire logic [7:0]  x_i,
  input  wire logic [7:0]  y_i,
  output      logic        mem_rd_o,
  output      logic [15:0] mem_addr_o,
  input  wire logic [7:0]  mem_rdata_i,
  output      logic        done_o,
  output      logic        err_o,
  output      logic [15:0] ea_o,
  output      logic [7:0]  imm_o,
  output      logic        imm_valid_o,
  output      logic [2:0]  len_o
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    oag_state_e  st;
    oag_mode_e   mode;
    logic        use_y;
    logic [15:0] pc;
    logic [7:0]  idx;
    logic [15:0] fetch_addr;
    logic [15:0] word;
    logic [15:0] ptr;
    logic        req;
    logic        done;
    logic        err;
    logic [15:0] ea;
    logic [7:0]  imm;
    logic        imm_valid;
    logic [2:0]  len;
  } oag_state_s;

  oag_state_s s_reg;
  oag_state_s s_next;

  oag_mem_if rd ();

  oag_mem_port u_port (
    .ref_clk_i   (ref_clk_i),
    .rst_i       (rst_i),
    .rd          (rd),
    .mem_rd_o    (mem_rd_o),
    .mem_addr_o  (mem_addr_o),
    .mem_rdata_i (mem_rdata_i)
  );

  // ****************************************
  // Helpers
  // ****************************************
  // Unsigned zero-extended add; no page wrap, so 8-bit sums reach 1FE
  function automatic logic [15:0] idx_add(input logic [15:0] base, input logic [7:0] idx);
    idx_add = base + {ZERO_BYTE, idx};
  endfunction

  function automatic logic is_short(input oag_mode_e m);
    case (m)
      OAG_M_DIR_SHORT, OAG_M_IDX_NONE, OAG_M_IDX_SHORT, OAG_M_IND_SHORT,
      OAG_M_INDIDX_SHORT:                  is_short = 1'b1;
      default:                             is_short = 1'b0;
    endcase
  endfunction

  function automatic logic [2:0] op_bytes(input oag_mode_e m);
    case (m)
      OAG_M_INHERENT, OAG_M_IDX_NONE:      op_bytes = LEN_ZERO;
      OAG_M_DIR_LONG, OAG_M_IDX_LONG:      op_bytes = LEN_TWO;
      default:                             op_bytes = LEN_ONE;
    endcase
  endfunction

  // Branch target: opcode address plus length already points past the instruction
  function automatic logic [15:0] rel_target(input logic [15:0] opc,
                                              input logic [2:0]  ln,
                                              input logic [7:0]  disp);
    rel_target = opc + 16'(ln) + {{8{disp[7]}}, disp};
  endfunction

  // ****************************************
  // Sequencer
  // ****************************************
  // Next state; req stays high until the port acknowledges the byte
  always_comb begin
    s_next      = s_reg;
    s_next.done = 1'b0;
    s_next.err  = 1'b0;
    case (s_reg.st)
      OAG_S_IDLE: begin
        if (start_i) begin
          s_next.mode      = oag_mode_e'(mode_i);
          s_next.use_y     = use_y_i;
          s_next.pc        = pc_i;
          s_next.idx       = use_y_i ? y_i : x_i;
          s_next.fetch_addr = pc_i + ADDR_STEP;
          s_next.word      = ZERO_ADDR;
          s_next.imm_valid = 1'b0;
          // Length: opcode, operand bytes, Y prebyte
          s_next.len = LEN_ONE + op_bytes(oag_mode_e'(mode_i)) + (use_y_i ? LEN_STEP : LEN_ZERO);
          if (rmw_i && !is_short(oag_mode_e'(mode_i))) begin
            s_next.err = 1'b1;
            s_next.st  = OAG_S_IDLE;
          end else if (op_bytes(oag_mode_e'(mode_i)) == LEN_ZERO) begin
            s_next.ea = idx_add(ZERO_ADDR, use_y_i ? y_i : x_i);
            s_next.st = OAG_S_DONE;
          end else begin
            s_next.req = 1'b1;
            s_next.st  = OAG_S_OPND1;
          end
        end
      end
      OAG_S_OPND1: begin
        if (rd.ack) begin
          s_next.req  = 1'b0;
          s_next.word = {ZERO_BYTE, rd.data};
          case (s_reg.mode)
            OAG_M_IMMEDIATE: begin
              s_next.imm       = rd.data;
              s_next.imm_valid = 1'b1;
              s_next.st        = OAG_S_DONE;
            end
            OAG_M_DIR_SHORT: begin
              s_next.ea = {ZERO_BYTE, rd.data};
              s_next.st = OAG_S_DONE;
            end
            OAG_M_IDX_SHORT: begin
              s_next.ea = idx_add({ZERO_BYTE, rd.data}, s_reg.idx);
              s_next.st = OAG_S_DONE;
            end
            OAG_M_REL_DIR: begin
              s_next.ea = rel_target(s_reg.pc, s_reg.len, rd.data);
              s_next.st = OAG_S_DONE;
            end
            OAG_M_DIR_LONG, OAG_M_IDX_LONG: begin
              s_next.word       = {rd.data, ZERO_BYTE};
              s_next.fetch_addr = s_reg.fetch_addr + ADDR_STEP;
              s_next.req        = 1'b1;
              s_next.st         = OAG_S_OPND2;
            end
            default: begin
              s_next.fetch_addr = {ZERO_BYTE, rd.data};
              s_next.req        = 1'b1;
              s_next.st         = OAG_S_PTR1;
            end
          endcase
        end
      end
      OAG_S_OPND2: begin
        if (rd.ack) begin
          s_next.req = 1'b0;
          if (s_reg.mode == OAG_M_DIR_LONG) begin
            s_next.ea = {s_reg.word[15:8], rd.data};
          end else begin
            s_next.ea = idx_add({s_reg.word[15:8], rd.data}, s_reg.idx);
          end
          s_next.st = OAG_S_DONE;
        end
      end
      OAG_S_PTR1: begin
        if (rd.ack) begin
          s_next.req = 1'b0;
          case (s_reg.mode)
            OAG_M_IND_SHORT: begin
              s_next.ea = {ZERO_BYTE, rd.data};
              s_next.st = OAG_S_DONE;
            end
            OAG_M_INDIDX_SHORT: begin
              s_next.ea = idx_add({ZERO_BYTE, rd.data}, s_reg.idx);
              s_next.st = OAG_S_DONE;
            end
            OAG_M_REL_IND: begin
              s_next.ea = rel_target(s_reg.pc, s_reg.len, rd.data);
              s_next.st = OAG_S_DONE;
            end
            default: begin
              s_next.ptr        = {rd.data, ZERO_BYTE};
              s_next.fetch_addr = s_reg.fetch_addr + ADDR_STEP;
              s_next.req        = 1'b1;
              s_next.st         = OAG_S_PTR2;
            end
          endcase
        end
      end
      OAG_S_PTR2: begin
        if (rd.ack) begin
          s_next.req = 1'b0;
          if (s_reg.mode == OAG_M_INDIDX_LONG) begin
            s_next.ea = idx_add({s_reg.ptr[15:8], rd.data}, s_reg.idx);
          end else begin
            s_next.ea = {s_reg.ptr[15:8], rd.data};
          end
          s_next.st = OAG_S_DONE;
        end
      end
      OAG_S_DONE: begin
        s_next.done = 1'b1;
        s_next.st   = OAG_S_IDLE;
      end
      default: begin
        s_next.st  = OAG_S_IDLE;
        s_next.req = 1'b0;
      end
    endcase
  end

  // State register; synchronous reset clears every output at once
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs come straight from the state register
  assign rd.req      = s_reg.req;
  assign rd.addr     = s_reg.fetch_addr;
  assign done_o      = s_reg.done;
  assign err_o       = s_reg.err;
  assign ea_o        = s_reg.ea;
  assign imm_o       = s_reg.imm;
  assign imm_valid_o = s_reg.imm_valid;
  assign len_o       = s_reg.len;

  // ****************************************
  // Checks
  // ****************************************
  // Short direct, indirect and no-offset results stay in page zero; short indexed ones reach 1FE
  page_zero_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    done_o && (s_reg.mode inside {OAG_M_DIR_SHORT, OAG_M_IND_SHORT, OAG_M_IDX_NONE}) |-> ea_o <= PAGE0_LAST)
    else $error("short mode left page zero");
  short_idx_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    done_o && (s_reg.mode inside {OAG_M_IDX_SHORT, OAG_M_INDIDX_SHORT}) |-> ea_o <= SHORT_IDX_MAX)
    else $error("short indexed beyond 1fe");
  rmw_refuse_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    s_reg.st == OAG_S_IDLE && start_i && rmw_i && (mode_i == OAG_M_DIR_LONG) |=> err_o && s_reg.st == OAG_S_IDLE)
    else $error("long rmw not refused");
  inherent_len_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    s_reg.st == OAG_S_IDLE && start_i && !rmw_i && mode_i == OAG_M_INHERENT && !use_y_i
    |=> len_o == LEN_ONE ##1 done_o && !mem_rd_o)
    else $error("inherent length or fetch wrong");
  imm_fetch_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    s_reg.st == OAG_S_IDLE && start_i && !rmw_i && mode_i == OAG_M_IMMEDIATE
    |-> ##2 mem_rd_o && mem_addr_o == $past(pc_i, 2) + ADDR_STEP ##[1:3] imm_valid_o)
    else $error("immediate byte not fetched");
  y_prebyte_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    s_reg.st == OAG_S_IDLE && start_i && !rmw_i && mode_i == OAG_M_IDX_NONE && use_y_i |=> len_o == LEN_TWO)
    else $error("y no offset length wrong");
  no_offset_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    s_reg.st == OAG_S_IDLE && start_i && !rmw_i && mode_i == OAG_M_IDX_NONE && !use_y_i
    |=> ea_o == {ZERO_BYTE, $past(x_i)})
    else $error("no offset address not index");
  // Word pointer order; the second strobe follows the high byte by one cycle
  word_ptr_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    s_reg.st == OAG_S_PTR1 && rd.ack && s_reg.mode == OAG_M_IND_LONG
    |=> s_reg.ptr[15:8] == $past(rd.data) ##1 mem_rd_o && mem_addr_o == $past(s_reg.fetch_addr, 2) + ADDR_STEP)
    else $error("word pointer order wrong");

endmodule

// ### verif/oag_mem_model.sv
`timescale 1ns/1ps
// ****************************************
// Program and data memory on the core bus
// ****************************************
module oag_mem_model (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  input  wire logic        mem_rd_i,
  input  wire logic [15:0] mem_addr_i,
  output      logic [7:0]  mem_rdata_o
);
  logic [7:0] mem [0:65535];

  // Clear storage so unread places never feed unknowns into the core
  initial begin
    foreach (mem[i]) begin
      mem[i] = 8'h00;
    end
  end

  // Preload one byte from the bench
  task automatic put(input logic [15:0] a, input logic [7:0] v);
    mem[a] = v;
  endtask

  // The port captures on the edge that ends its strobe, so data is laid on the falling
  // edge inside the strobe cycle; off strobe it flips, so a late capture is caught
  always_ff @(negedge ref_clk_i) begin
    if (rst_i) begin
      mem_rdata_o <= 8'h00;
    end else if (mem_rd_i) begin
      mem_rdata_o <= mem[mem_addr_i];
    end else begin
      mem_rdata_o <= ~mem_rdata_o;
    end
  end
endmodule

// ### verif/oag_top_tb_top.sv
`timescale 1ns/1ps
module oag_top_tb_top;
  import oag_pkg::*;
  // ****************************************
  // Signals
  // ****************************************
  logic        clk       = 1'b0;
  logic        rst       = 1'b1;
  logic        start     = 1'b0;
  logic [4:0]  mode      = 5'h00;
  logic        use_y     = 1'b0;
  logic        rmw       = 1'b0;
  logic [15:0] pc        = 16'h0000;
  logic [7:0]  x         = 8'h00;
  logic [7:0]  y         = 8'h00;
  logic        mem_rd;
  logic [15:0] mem_addr;
  logic [7:0]  mem_rdata;
  logic        done;
  logic        err;
  logic [15:0] ea;
  logic [7:0]  imm;
  logic        imm_valid;
  logic [2:0]  len;
  int          n_errors  = 0;
  int          checks    = 0;
  int          lat;
  int          elat;
  int          nrd;
  logic        saw_err;

  // Free-running core clock
  always #5 clk = ~clk;

  oag_top oag_top_inst (.ref_clk_i(clk), .rst_i(rst), .start_i(start), .mode_i(mode), .use_y_i(use_y),
    .rmw_i(rmw), .pc_i(pc), .x_i(x), .y_i(y), .mem_rd_o(mem_rd), .mem_addr_o(mem_addr),
    .mem_rdata_i(mem_rdata), .done_o(done), .err_o(err), .ea_o(ea), .imm_o(imm),
    .imm_valid_o(imm_valid), .len_o(len));

  oag_mem_model oag_mem_model_inst (.ref_clk_i(clk), .rst_i(rst), .mem_rd_i(mem_rd), .mem_addr_i(mem_addr),
    .mem_rdata_o(mem_rdata));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, what, seen, exp);
    end
  endtask

  // One decode; erd is the expected byte reads, or -1 when refusal is expected
  // Each read costs three cycles (strobe, capture, consume); refusal shows at once
  task automatic run(input logic [4:0] m, input logic uy, input logic rw, input logic [7:0] xv, input int erd);
    @(negedge clk);
    start = 1'b1;
    mode = m;
    use_y = uy;
    rmw = rw;
    pc = 16'h4000;
    x = xv;
    y = xv;
    @(negedge clk);
    start = 1'b0;
    lat = 0;
    nrd = 0;
    elat = 0;
    saw_err = 1'b0;
    // Bounded wait: a refused decode never finishes, so the cap is its normal exit
    while (done !== 1'b1 && lat < 20) begin
      if (err === 1'b1 && saw_err === 1'b0) begin
        saw_err = 1'b1;
        elat = lat;
      end
      if (mem_rd === 1'b1 && nrd == 0) begin
        chk(mem_addr, 16'h4001, "first operand fetch");
      end
      if (mem_rd === 1'b1) nrd++;
      @(negedge clk);
      lat++;
    end
    if (erd < 0) begin
      chk({15'h0000, saw_err}, 16'h0001, "refusal pulse");
      chk(16'(elat), 16'h0000, "refusal timing");
      chk(16'(nrd), 16'h0000, "reads on refusal");
      chk(16'(lat), 16'h0014, "done on refusal");
    end else begin
      chk({15'h0000, saw_err}, 16'h0000, "spurious refusal");
      chk(16'(nrd), 16'(erd), "byte reads");
      chk(16'(lat), 16'(1 + 3 * erd), "decode cycles");
    end
  endtask

  task automatic put(input logic [15:0] a, input logic [7:0] v);
    oag_mem_model_inst.put(a, v);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_inh_imm;
    run(OAG_M_INHERENT, 1'b0, 1'b0, 8'h00, 0);
    chk({13'h0000, len}, 16'h0001, "inherent length");
    put(16'h4001, 8'ha5);
    run(OAG_M_IMMEDIATE, 1'b0, 1'b0, 8'h00, 1);
    chk({8'h00, imm}, 16'h00a5, "immediate byte");
    chk({15'h0000, imm_valid}, 16'h0001, "immediate valid");
    chk({13'h0000, len}, 16'h0002, "immediate length");
    $display("test inherent/immediate done");
  endtask

  task automatic t_direct;
    put(16'h4001, 8'hff);
    run(OAG_M_DIR_SHORT, 1'b0, 1'b0, 8'h00, 1);
    chk(ea, 16'h00ff, "short direct address");
    chk({13'h0000, len}, 16'h0002, "short direct length");
    put(16'h4002, 8'hee);
    run(OAG_M_DIR_LONG, 1'b0, 1'b0, 8'h00, 2);
    chk(ea, 16'hffee, "long direct address");
    chk({13'h0000, len}, 16'h0003, "long direct length");
    $display("test direct done");
  endtask

  task automatic t_indexed;
    run(OAG_M_IDX_NONE, 1'b0, 1'b0, 8'h9c, 0);
    chk(ea, 16'h009c, "no offset x address");
    chk({13'h0000, len}, 16'h0001, "no offset x length");
    run(OAG_M_IDX_NONE, 1'b1, 1'b0, 8'h3e, 0);
    chk(ea, 16'h003e, "no offset y address");
    chk({13'h0000, len}, 16'h0002, "no offset y length");
    put(16'h4001, 8'hff);
    run(OAG_M_IDX_SHORT, 1'b0, 1'b0, 8'hff, 1);
    chk(ea, 16'h01fe, "short indexed top");
    run(OAG_M_IDX_SHORT, 1'b1, 1'b0, 8'h81, 1);
    chk(ea, 16'h0180, "short indexed y");
    put(16'h4001, 8'h12);
    put(16'h4002, 8'hf0);
    run(OAG_M_IDX_LONG, 1'b0, 1'b0, 8'h20, 2);
    chk(ea, 16'h1310, "long indexed carry");
    chk({13'h0000, len}, 16'h0003, "long indexed length");
    $display("test indexed done");
  endtask

  task automatic t_indirect;
    put(16'h4001, 8'hff);
    put(16'h00ff, 8'hff);
    put(16'h0100, 8'h01);
    run(OAG_M_IND_SHORT, 1'b0, 1'b0, 8'h00, 2);
    chk(ea, 16'h00ff, "short indirect");
    run(OAG_M_IND_LONG, 1'b0, 1'b0, 8'h00, 3);
    chk(ea, 16'hff01, "long indirect word order");
    run(OAG_M_INDIDX_SHORT, 1'b0, 1'b0, 8'hff, 2);
    chk(ea, 16'h01fe, "short indirect indexed top");
    run(OAG_M_INDIDX_LONG, 1'b0, 1'b0, 8'h20, 3);
    chk(ea, 16'hff21, "long indirect indexed");
    $display("test indirect done");
  endtask

  task automatic t_relative;
    put(16'h4001, 8'h80);
    run(OAG_M_REL_DIR, 1'b0, 1'b0, 8'h00, 1);
    chk(ea, 16'h3f82, "relative back 128");
    chk({13'h0000, len}, 16'h0002, "relative length");
    put(16'h4001, 8'h7f);
    run(OAG_M_REL_DIR, 1'b0, 1'b0, 8'h00, 1);
    chk(ea, 16'h4081, "relative forward 127");
    put(16'h4001, 8'h30);
    put(16'h0030, 8'hfe);
    run(OAG_M_REL_IND, 1'b0, 1'b0, 8'h00, 2);
    chk(ea, 16'h4000, "relative indirect back 2");
    $display("test relative done");
  endtask

  // Reset in mid-decode must clear mem_rd, done, err, len and ea and leave the sequencer idle
  task automatic t_reset;
    @(negedge clk);
    start = 1'b1;
    mode = OAG_M_DIR_LONG;
    use_y = 1'b0;
    rmw = 1'b0;
    @(negedge clk);
    start = 1'b0;
    repeat (2) @(negedge clk);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    chk({10'h000, mem_rd, done, err, len}, 16'h0000, "flags after mid reset");
    chk(ea, 16'h0000, "address after mid reset");
    run(OAG_M_IDX_NONE, 1'b0, 1'b0, 8'h5a, 0);
    chk(ea, 16'h005a, "decode after mid reset");
    $display("test mid-run reset done");
  endtask

  task automatic t_rmw;
    logic [4:0] bad [6];
    bad = '{5'h03, 5'h06, 5'h08, 5'h0a, 5'h0b, 5'h0c};
    foreach (bad[i]) begin
      run(bad[i], 1'b0, 1'b1, 8'h00, -1);
    end
    put(16'h4001, 8'h44);
    run(OAG_M_DIR_SHORT, 1'b0, 1'b1, 8'h00, 1);
    chk(ea, 16'h0044, "short rmw accepted");
    run(OAG_M_IDX_NONE, 1'b0, 1'b1, 8'h21, 0);
    chk(ea, 16'h0021, "no offset rmw accepted");
    $display("test read-modify-write done");
  endtask

  // ****************************************
  // Verdict and run control
  // ****************************************
  task automatic results;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Watchdog: the tests need well under a thousand cycles
  initial begin
    #50000;
    n_errors++;
    results();
  end

  // Main sequence
  initial begin
    repeat (10) @(negedge clk);
    rst = 1'b0;
    chk({15'h0000, done}, 16'h0000, "done after reset");
    chk(ea, 16'h0000, "address after reset");
    t_inh_imm();
    t_direct();
    t_indexed();
    t_indirect();
    t_relative();
    t_rmw();
    t_reset();
    results();
  end
endmodule
